// >>> hw/ess_defs.svh
// register offsets, field positions, reset values and timing constants
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH

// timing
`define ESS_CLK_PERIOD_NS 4
`define ESS_SEC_NS        1000000000
`define ESS_SEC_PER_MIN   16'd60

// configuration word indices, byte offset is index times four
`define ESS_NCFG      10
`define ESS_R_CTRL    0
`define ESS_R_NOM1    1
`define ESS_R_NOM2    2
`define ESS_R_LIM     3
`define ESS_R_OVS     4
`define ESS_R_CHG     5
`define ESS_R_ST1     6
`define ESS_R_ST2     7
`define ESS_R_STP     8
`define ESS_R_CUT     9
`define ESS_A_STATUS  8'h28
`define ESS_A_STATE   8'h2c

// control word bits
`define ESS_B_SECFREQ 0
`define ESS_B_PREASGN 1
`define ESS_B_LOSCHK  2
`define ESS_F_LOSACT  4:3
`define ESS_B_HEATM   5

// fields
`define ESS_F_NOM     15:0
`define ESS_F_LW      7:0
`define ESS_F_LSD     15:8
`define ESS_F_HW      23:16
`define ESS_F_HSD     31:24
`define ESS_F_OVS     7:0
`define ESS_F_SPDT    15:8
`define ESS_F_LOST    23:16
`define ESS_F_CWARN   7:0
`define ESS_F_CSD     15:8
`define ESS_F_CHGT    23:16
`define ESS_F_DELAY   7:0
`define ESS_F_PREH    15:8
`define ESS_F_CRANK   23:16
`define ESS_F_REST    31:24
`define ESS_F_TRIES   2:0
`define ESS_F_CHOKE   15:8
`define ESS_F_HEATT   23:16
`define ESS_F_HEATC   31:24
`define ESS_F_COOL    9:0
`define ESS_F_STOPT   22:16
`define ESS_F_CUT     15:0

// reset values
`define ESS_RST_CTRL  32'h0000_0000
`define ESS_RST_NOM1  32'h0000_05dc
`define ESS_RST_NOM2  32'h0000_0708
`define ESS_RST_LIM   32'h0f0a_0f0a
`define ESS_RST_OVS   32'h0000_030a
`define ESS_RST_CHG   32'h0001_283c
`define ESS_RST_ST1   32'h0a06_0001
`define ESS_RST_ST2   32'h0004_0503
`define ESS_RST_STP   32'h000a_0078
`define ESS_RST_CUT   32'h0000_01f4

// sticky status bits
`define ESS_FL_LOWW   0
`define ESS_FL_LOWS   1
`define ESS_FL_HIW    2
`define ESS_FL_HIS    3
`define ESS_FL_LOST   4
`define ESS_FL_CHGW   5
`define ESS_FL_CHGS   6
`define ESS_FL_STOPF  7
`define ESS_FL_STARTF 8
`define ESS_FL_DUMP   9
`define ESS_SD_MASK   10'h14a

`endif

// >>> hw/ess_pkg.sv
// types of the engine start and stop sequencer
package ess_pkg;

    typedef enum logic [3:0] {
        ESS_IDLE,
        ESS_DELAY,
        ESS_PREHEAT,
        ESS_CRANK,
        ESS_REST,
        ESS_WARMUP,
        ESS_LOADED,
        ESS_COOLDOWN,
        ESS_STOPPING
    } ess_state_t;

    typedef struct packed {
        logic [1:0]       mf_sync;
        logic [1:0]       sp_sync;
        logic [31:0]      div;
        logic             tick;
        ess_state_t       st;
        logic [15:0]      tmr;
        logic [2:0]       tries;
        logic [7:0]       spd_tmr;
        logic [7:0]       los_tmr;
        logic [7:0]       chg_tmr;
        logic             fuel;
        logic             preheat;
        logic             crank;
        logic             choke;
        logic             stop;
        logic             load;
        logic [9:0]       flags;
        logic [9:0][31:0] cfg;
        logic [31:0]      prdata;
        logic             pslverr;
    } ess_regs_t;

endpackage

// >>> hw/ess_sequencer.sv
// engine start and stop sequencer with speed and charge supervision
//
// Contract
// - nominal speed 1500, 1800 on secondary
// - low speed: warn -10%, shutdown -15%
// - high speed: warn +10%, shutdown +15%
// - speed fault after fail time, 3 s
// - overshoot above high shutdown trips at once
// - speed loss check, selectable fault action
// - speed loss declared after loss timer
// - charge below 6.0 V warns
// - charge below 4.0 V shuts down
// - charge fault after fail time, 1 s
// - start delay in minutes before fuel
// - preheat with fuel, before cranking
// - crank limited, ends early on firing
// - rest between attempts, limited attempt count
// - choke with crank, released by timer/run
// - warm-up by time or time plus temperature
// - cooldown unloaded before stopping
// - stop output timed, stop failure warning
// - crank cut at crank-cut speed
`timescale 1ns/100ps
`include "ess_defs.svh"

module ess_sequencer
    import ess_pkg::*;
#(
    parameter int TICK_CYCLES = `ESS_SEC_NS / `ESS_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pins and measurements
    input  wire logic        mains_fail,
    input  wire logic        speed_present,
    input  wire logic [15:0] speed_rpm,
    input  wire logic [15:0] charge_dv,
    input  wire logic [7:0]  coolant_c,
    // engine relays
    output logic             fuel_out,
    output logic             preheat_out,
    output logic             crank_out,
    output logic             choke_out,
    output logic             stop_out,
    output logic             load_request,
    output logic             stop_failure_warning,
    output logic             shutdown_active
);

    ////////////////////////////////////////////////////////////////////////
    // decoding

    // index of a configuration word, ESS_NCFG when the address is none
    function automatic logic [3:0] cfg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = 4'(`ESS_NCFG);
        if (a[1:0] == 2'h0 && a[7:2] < 6'(`ESS_NCFG)) begin
            idx = a[5:2];
        end
        return idx;
    endfunction

    function automatic logic in_run(input ess_state_t s);
        return s == ESS_WARMUP || s == ESS_LOADED || s == ESS_COOLDOWN;
    endfunction

    localparam logic [9:0][31:0] CFG_RST = {
        `ESS_RST_CUT, `ESS_RST_STP, `ESS_RST_ST2, `ESS_RST_ST1,
        `ESS_RST_CHG, `ESS_RST_OVS, `ESS_RST_LIM, `ESS_RST_NOM2,
        `ESS_RST_NOM1, `ESS_RST_CTRL
    };

    ess_regs_t r_reg;
    ess_regs_t r_next;

    logic [31:0] ctrl;
    logic [15:0] nom;
    logic [31:0] lim;
    logic [31:0] ovs;
    logic [31:0] chg;
    logic [31:0] st1;
    logic [31:0] st2;
    logic [31:0] stp;
    logic        fired;
    logic        mf;
    logic [31:0] s100;
    logic [39:0] s10k;
    logic [39:0] ovs_th;
    logic        lo_w;
    logic        lo_s;
    logic        hi_w;
    logic        hi_s;
    logic        hi_now;
    logic        spd_bad;
    logic        c_w;
    logic        c_s;
    logic        lost;
    logic [9:0]  ev;
    logic [9:0]  clr;
    logic        sd_any;
    logic        loss_sd;
    logic        dump;
    logic [3:0]  widx;
    logic        wr;
    logic        rd;

    ////////////////////////////////////////////////////////////////////////
    // supervision terms

    always_comb begin
        ctrl  = r_reg.cfg[`ESS_R_CTRL];
        nom   = ctrl[`ESS_B_SECFREQ] ? r_reg.cfg[`ESS_R_NOM2][`ESS_F_NOM]
                                     : r_reg.cfg[`ESS_R_NOM1][`ESS_F_NOM];
        lim   = r_reg.cfg[`ESS_R_LIM];
        ovs   = r_reg.cfg[`ESS_R_OVS];
        chg   = r_reg.cfg[`ESS_R_CHG];
        st1   = r_reg.cfg[`ESS_R_ST1];
        st2   = r_reg.cfg[`ESS_R_ST2];
        stp   = r_reg.cfg[`ESS_R_STP];
        mf    = r_reg.mf_sync[1];
        fired = speed_rpm >= r_reg.cfg[`ESS_R_CUT][`ESS_F_CUT];
        s100  = 32'(speed_rpm) * 32'd100;
        s10k  = 40'(speed_rpm) * 40'd10000;
        lo_w  = s100 < 32'(nom) * (32'd100 - 32'(lim[`ESS_F_LW]));
        lo_s  = s100 < 32'(nom) * (32'd100 - 32'(lim[`ESS_F_LSD]));
        hi_w  = s100 > 32'(nom) * (32'd100 + 32'(lim[`ESS_F_HW]));
        hi_s  = s100 > 32'(nom) * (32'd100 + 32'(lim[`ESS_F_HSD]));
        ovs_th = 40'(nom) * (40'd100 + 40'(lim[`ESS_F_HSD]))
               * (40'd100 + 40'(ovs[`ESS_F_OVS]));
        hi_now = r_reg.st == ESS_LOADED && s10k > ovs_th;
        spd_bad = r_reg.st == ESS_LOADED && (lo_w || hi_w);
        c_w   = in_run(r_reg.st) && charge_dv < 16'(chg[`ESS_F_CWARN]);
        c_s   = in_run(r_reg.st) && charge_dv < 16'(chg[`ESS_F_CSD]);
        lost  = in_run(r_reg.st) && ctrl[`ESS_B_LOSCHK]
                && !r_reg.sp_sync[1];
        // a lost signal with action 0 stops the engine; the term follows
        // the live action setting, the sticky bit only records the loss
        loss_sd = r_reg.flags[`ESS_FL_LOST]
                  && ctrl[`ESS_F_LOSACT] == 2'd0;
        sd_any = |(r_reg.flags & `ESS_SD_MASK) || loss_sd;
        dump  = r_reg.flags[`ESS_FL_DUMP];
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;
        ev     = 10'h000;
        clr    = 10'h000;
        wr     = psel && penable && pwrite;
        rd     = psel && !penable;
        widx   = cfg_index(paddr);

        // synchronisers
        // only the second stage feeds the logic below
        r_next.mf_sync = {r_reg.mf_sync[0], mains_fail};
        r_next.sp_sync = {r_reg.sp_sync[0], speed_present};

        // one-second tick
        // every timer advances on this pulse, never on the raw clock
        r_next.tick = 1'b0;
        if (r_reg.div == 32'(TICK_CYCLES - 1)) begin
            r_next.div  = 32'h0;
            r_next.tick = 1'b1;
        end else begin
            r_next.div = r_reg.div + 32'h1;
        end

        // speed fault timer
        if (!spd_bad) begin
            r_next.spd_tmr = 8'h00;
        end else if (r_reg.tick && r_reg.spd_tmr != 8'hff) begin
            r_next.spd_tmr = r_reg.spd_tmr + 8'h01;
        end
        if (spd_bad && r_reg.spd_tmr >= ovs[`ESS_F_SPDT]) begin
            ev[`ESS_FL_LOWW] = lo_w;
            ev[`ESS_FL_LOWS] = lo_s;
            ev[`ESS_FL_HIW]  = hi_w;
            ev[`ESS_FL_HIS]  = hi_s;
        end
        if (hi_now) begin
            ev[`ESS_FL_HIS] = 1'b1;
        end

        // speed loss timer
        if (!lost) begin
            r_next.los_tmr = 8'h00;
        end else if (r_reg.tick && r_reg.los_tmr != 8'hff) begin
            r_next.los_tmr = r_reg.los_tmr + 8'h01;
        end
        if (lost && r_reg.los_tmr >= ovs[`ESS_F_LOST]) begin
            ev[`ESS_FL_LOST] = 1'b1;
            ev[`ESS_FL_DUMP] = ctrl[`ESS_F_LOSACT] == 2'd1;
        end

        // charge fault timer
        if (!c_w) begin
            r_next.chg_tmr = 8'h00;
        end else if (r_reg.tick && r_reg.chg_tmr != 8'hff) begin
            r_next.chg_tmr = r_reg.chg_tmr + 8'h01;
        end
        if (c_w && r_reg.chg_tmr >= chg[`ESS_F_CHGT]) begin
            ev[`ESS_FL_CHGW] = 1'b1;
            ev[`ESS_FL_CHGS] = c_s;
        end

        // sequence
        case (r_reg.st)
            ESS_IDLE: begin
                // a pending load dump also keeps the engine at rest
                if (mf && !sd_any && !dump) begin
                    r_next.st = ESS_DELAY;
                end
            end
            ESS_DELAY: begin
                // mains return or a pending shutdown abandons the start
                if (!mf || sd_any) begin
                    r_next.st = ESS_IDLE;
                end else if (r_reg.tmr >=
                             16'(st1[`ESS_F_DELAY]) * `ESS_SEC_PER_MIN) begin
                    r_next.st    = ESS_PREHEAT;
                    r_next.tries = 3'h0;
                end
            end
            ESS_PREHEAT: begin
                if (r_reg.tmr >= 16'(st1[`ESS_F_PREH])) begin
                    r_next.st    = ESS_CRANK;
                    r_next.tries = r_reg.tries + 3'h1;
                end
            end
            ESS_CRANK: begin
                if (fired) begin
                    r_next.st = ESS_WARMUP;
                end else if (r_reg.tmr >= 16'(st1[`ESS_F_CRANK])) begin
                    // the last attempt timing out latches start failure
                    if (r_reg.tries >= st2[`ESS_F_TRIES]) begin
                        ev[`ESS_FL_STARTF] = 1'b1;
                        r_next.st = ESS_STOPPING;
                    end else begin
                        r_next.st = ESS_REST;
                    end
                end
            end
            ESS_REST: begin
                if (r_reg.tmr >= 16'(st1[`ESS_F_REST])) begin
                    r_next.st    = ESS_CRANK;
                    r_next.tries = r_reg.tries + 3'h1;
                end
            end
            ESS_WARMUP: begin
                if (r_reg.tmr >= 16'(st2[`ESS_F_HEATT]) &&
                    (!ctrl[`ESS_B_HEATM] ||
                     coolant_c >= st2[`ESS_F_HEATC])) begin
                    r_next.st = ESS_LOADED;
                end
            end
            ESS_LOADED: begin
                if (!mf || dump) begin
                    r_next.st = ESS_COOLDOWN;
                end
            end
            ESS_COOLDOWN: begin
                if (r_reg.tmr >= 16'(stp[`ESS_F_COOL])) begin
                    r_next.st = ESS_STOPPING;
                end else if (mf && !dump) begin
                    r_next.st = ESS_LOADED;
                end
            end
            ESS_STOPPING: begin
                // zero speed ends the stop early; an engine still above
                // crank-cut speed when the time runs out failed to halt
                if (r_reg.tmr >= 16'(stp[`ESS_F_STOPT])) begin
                    ev[`ESS_FL_STOPF] = fired;
                    r_next.st = ESS_IDLE;
                end else if (speed_rpm == 16'h0) begin
                    r_next.st = ESS_IDLE;
                end
            end
            default: begin
                r_next.st = ESS_IDLE;
            end
        endcase
        // any shutdown in the running sequence forces the stop
        if (sd_any && r_reg.st != ESS_IDLE && r_reg.st != ESS_DELAY
            && r_reg.st != ESS_STOPPING) begin
            r_next.st = ESS_STOPPING;
        end

        // state timer restarts on every state change
        if (r_next.st != r_reg.st) begin
            r_next.tmr = 16'h0;
        end else if (r_reg.tick && r_reg.tmr != 16'hffff) begin
            r_next.tmr = r_reg.tmr + 16'h1;
        end

        // relay outputs follow the next state
        // so each relay moves on the same edge as the state itself
        r_next.fuel    = r_next.st == ESS_PREHEAT || r_next.st == ESS_CRANK
                      || r_next.st == ESS_REST || in_run(r_next.st);
        r_next.preheat = r_next.st == ESS_PREHEAT && ctrl[`ESS_B_PREASGN];
        r_next.crank   = r_next.st == ESS_CRANK && !fired;
        r_next.choke   = r_next.st == ESS_CRANK && !fired
                      && r_next.tmr < 16'(st2[`ESS_F_CHOKE]);
        r_next.stop    = r_next.st == ESS_STOPPING;
        r_next.load    = r_next.st == ESS_LOADED;

        // configuration writes and status clear
        if (wr && widx != 4'(`ESS_NCFG)) begin
            r_next.cfg[widx] = pwdata;
        end
        if (wr && paddr == `ESS_A_STATUS) begin
            clr = pwdata[9:0];
        end
        // a fault event wins over a clear in the same cycle
        r_next.flags = (r_reg.flags & ~clr) | ev;

        // read data captured in the setup phase
        if (rd) begin
            r_next.pslverr = 1'b0;
            if (widx != 4'(`ESS_NCFG)) begin
                r_next.prdata = r_reg.cfg[widx];
            end else if (paddr == `ESS_A_STATUS) begin
                r_next.prdata = {22'h0, r_reg.flags};
            end else if (paddr == `ESS_A_STATE) begin
                r_next.prdata = {17'h0, r_reg.tries, r_reg.load, r_reg.stop,
                                 r_reg.choke, r_reg.crank, r_reg.preheat,
                                 r_reg.fuel, 2'h0, r_reg.st};
            end else begin
                r_next.prdata  = 32'h0;
                r_next.pslverr = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg         <= '0;
            r_reg.st      <= ESS_IDLE;
            r_reg.cfg     <= CFG_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready               = 1'b1;
    assign prdata               = r_reg.prdata;
    assign pslverr              = r_reg.pslverr;
    assign fuel_out             = r_reg.fuel;
    assign preheat_out          = r_reg.preheat;
    assign crank_out            = r_reg.crank;
    assign choke_out            = r_reg.choke;
    assign stop_out             = r_reg.stop;
    assign load_request         = r_reg.load;
    assign stop_failure_warning = r_reg.flags[`ESS_FL_STOPF];
    assign shutdown_active      = sd_any;

endmodule

// >>> tb/ess_monitor.sv
// concurrent checks on the ports of the engine sequencer
`timescale 1ns/100ps
module ess_monitor (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // engine
    input wire logic [15:0] speed_rpm,
    input wire logic        fuel_out,
    input wire logic        preheat_out,
    input wire logic        crank_out,
    input wire logic        choke_out,
    input wire logic        stop_out,
    input wire logic        load_request,
    input wire logic        stop_failure_warning,
    input wire logic        shutdown_active
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    unmapped_read_a: assert property (psel && !penable && !pwrite
        && paddr >= 8'h30 |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    reset_quiet_a: assert property ($rose(rst_n) |-> !fuel_out
        && !crank_out && !stop_out && !load_request)
        else $error("relay active after reset");
    choke_with_a: assert property ($rose(crank_out) |-> choke_out)
        else $error("choke missing at crank");
    choke_release_a: assert property (choke_out |-> crank_out)
        else $error("choke held without crank");
    preheat_first_a: assert property (crank_out |-> fuel_out
        && !preheat_out)
        else $error("crank with preheat or without fuel");
    crank_cut_a: assert property (crank_out
        && speed_rpm >= 16'h01f4 |-> ##[1:3] !crank_out)
        else $error("crank not cut");
    load_guard_a: assert property (load_request |-> fuel_out
        && !crank_out && !stop_out)
        else $error("load while not running");
    shutdown_drop_a: assert property ($rose(shutdown_active)
        |-> ##[1:3] !load_request)
        else $error("load kept after shutdown");
    stop_fail_a: assert property ($rose(stop_failure_warning)
        |-> $past(stop_out))
        else $error("stop failure without stop");
endmodule

bind ess_sequencer ess_monitor u_mon (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready,
    .prdata, .pslverr, .speed_rpm, .fuel_out, .preheat_out,
    .crank_out, .choke_out, .stop_out, .load_request,
    .stop_failure_warning, .shutdown_active
);

// >>> tb/ess_engine_model.sv
// behavioural engine with speed pickup for the sequencer bench
`timescale 1ns/100ps
module ess_engine_model (
    // relays
    input wire logic        ref_clk,
    input wire logic        fuel_out,
    input wire logic        crank_out,
    input wire logic        stop_out,
    // bench controls
    input wire logic        fire_en,
    input wire logic        hang,
    input wire logic        sig_lost,
    input wire logic [15:0] run_rpm,
    // measurements
    output logic [15:0]     speed_rpm,
    output logic            speed_present
);
    logic running = 1'h0;

    // a jammed engine ignores fuel cut and stop solenoid
    always @(posedge ref_clk) begin
        if (crank_out && fire_en)
            running <= 1'h1;
        else if ((!fuel_out || stop_out) && !hang)
            running <= 1'h0;
    end
    assign speed_rpm = running ? run_rpm : 16'h0000;
    assign speed_present = running && !sig_lost;
endmodule

// >>> tb/ess_sequencer_tb_top.sv
// self-checking bench of the engine start and stop sequencer
`timescale 1ns/100ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin \
    err_total++; $display("BAD %0t %s", $time, m); end end
`define WT(c, n) begin k = 0; while (!(c) && k < (n)) begin \
    @(posedge ref_clk); k++; end `CHK(c, 1'h1, "wait") end
module ess_sequencer_tb_top;
    logic        ref_clk = 1'h0, rst_n = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        mains_fail = 1'h0, fire_en = 1'h0;
    logic        hang = 1'h0, sig_lost = 1'h0;
    logic [15:0] charge_dv = 16'h0082, run_rpm = 16'h05dc;
    logic [7:0]  coolant_c = 8'h28;
    logic        pready, pslverr, speed_present, fuel_out, preheat_out;
    logic        crank_out, choke_out, stop_out, load_request;
    logic        stop_failure_warning, shutdown_active, cpre = 1'h0;
    logic [31:0] prdata;
    logic [15:0] speed_rpm;
    int          cranks = 0, clen = 0, k, err_total = 0, checks = 0;
    logic [31:0] rst_val [1:9] = '{32'h0000_05dc, 32'h0000_0708,
        32'h0f0a_0f0a, 32'h0000_030a, 32'h0001_283c, 32'h0a06_0001,
        32'h0004_0503, 32'h000a_0078, 32'h0000_01f4};

    always #2 ref_clk = ~ref_clk;

    ess_sequencer #(.TICK_CYCLES(10)) dut (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .mains_fail, .speed_present,
        .speed_rpm, .charge_dv, .coolant_c, .fuel_out, .preheat_out,
        .crank_out, .choke_out, .stop_out, .load_request,
        .stop_failure_warning, .shutdown_active
    );
    ess_engine_model eng (
        .ref_clk, .fuel_out, .crank_out, .stop_out, .fire_en, .hang,
        .sig_lost, .run_rpm, .speed_rpm, .speed_present
    );

    // counts crank attempts and keeps the length of the last one
    always @(posedge ref_clk) begin
        cpre <= crank_out;
        if (crank_out && !cpre)
            cranks <= cranks + 1;
        clen <= crank_out ? (cpre ? clen + 1 : 1) : clen;
    end
    ////////////////////////////////////////////////
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do
            @(posedge ref_clk);
        while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask

    task t_regs;
        for (int i = 1; i < 10; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            `CHK(rd, rst_val[i], "reset value")
        end
        apb(1'h0, 8'h40, 32'h0);
        `CHK({pslverr, rd}, 33'h1_0000_0000, "unmapped read")
        apb(1'h1, 8'h18, 32'h0202_0201);
        apb(1'h1, 8'h1c, 32'h0002_0102);
        apb(1'h1, 8'h20, 32'h0002_0002);
        apb(1'h1, 8'h00, 32'h0000_0016);
    endtask

    task t_fail;
        mains_fail <= 1'h1;
        `WT(fuel_out, 700)
        `CHK(k > 595 && k < 620, 1'h1, "start delay")
        `WT(preheat_out, 4)
        `WT(crank_out, 40)
        `CHK(k > 9, 1'h1, "preheat time")
        `WT(shutdown_active, 200)
        `CHK(cranks, 2, "attempts")
        `CHK(clen > 10 && clen < 32, 1'h1, "crank length")
        apb(1'h0, 8'h28, 32'h0);
        `CHK(rd[8], 1'h1, "start failure")
    endtask

    task run_up;
        `WT(speed_rpm == 16'h0000, 5)
        `WT(!stop_out, 60)
        fire_en <= 1'h1;
        run_rpm <= 16'h05dc;
        apb(1'h1, 8'h28, 32'h0000_03ff);
        `WT(crank_out, 700)
        `WT(!crank_out, 40)
        `CHK(clen < 5, 1'h1, "crank cut")
        `WT(load_request, 30)
        `CHK(k > 9 && k < 26, 1'h1, "warm-up")
    endtask

    task t_band(input logic [15:0] w, input logic [15:0] s, input int b);
        run_up();
        run_rpm <= w;
        repeat (16) @(posedge ref_clk);
        apb(1'h0, 8'h28, 32'h0);
        `CHK(rd[b], 1'h0, "early speed fault")
        repeat (30) @(posedge ref_clk);
        apb(1'h0, 8'h28, 32'h0);
        `CHK({shutdown_active, rd[b+1], rd[b]}, 3'h1, "warn")
        run_rpm <= s;
        `WT(shutdown_active, 60)
        apb(1'h0, 8'h28, 32'h0);
        `CHK(rd[b+1], 1'h1, "speed shutdown")
    endtask

    task t_over;
        run_up();
        run_rpm <= 16'h076c;
        `WT(shutdown_active, 6)
        apb(1'h0, 8'h28, 32'h0);
        `CHK(rd[3], 1'h1, "overshoot")
    endtask

    task t_stop;
        run_up();
        charge_dv <= 16'h0032;
        sig_lost <= 1'h1;
        repeat (35) @(posedge ref_clk);
        apb(1'h0, 8'h28, 32'h0);
        `CHK({shutdown_active, rd[6:4]}, 4'h3, "charge, loss")
        charge_dv <= 16'h0082;
        hang <= 1'h1;
        mains_fail <= 1'h0;
        `WT(!load_request, 6)
        `CHK({fuel_out, stop_out}, 2'h2, "cooldown")
        `WT(stop_out, 30)
        `CHK(k > 8, 1'h1, "cooldown length")
        `WT(stop_failure_warning, 40)
        `WT(!stop_out, 3)
    endtask

    task t_alt;
        hang <= 1'h0;
        sig_lost <= 1'h0;
        run_rpm <= 16'h076c;
        apb(1'h1, 8'h28, 32'h0000_03ff);
        apb(1'h1, 8'h1c, 32'h5002_0102);
        apb(1'h1, 8'h10, 32'h0002_030a);
        apb(1'h1, 8'h00, 32'h0000_0025);
        mains_fail <= 1'h1;
        `WT(crank_out, 700)
        `WT(!crank_out, 40)
        repeat (40) @(posedge ref_clk);
        `CHK(load_request, 1'h0, "heating temperature")
        coolant_c <= 8'h50;
        `WT(load_request, 4)
        repeat (40) @(posedge ref_clk);
        apb(1'h0, 8'h28, 32'h0);
        `CHK({shutdown_active, rd[3:0]}, 5'h00, "secondary nominal")
        sig_lost <= 1'h1;
        `WT(shutdown_active, 40)
        `CHK(k > 9, 1'h1, "loss timer")
        apb(1'h0, 8'h28, 32'h0);
        `CHK({rd[9], rd[4]}, 2'h1, "loss shutdown")
    endtask

    task report_and_stop;
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        t_regs();
        t_fail();
        t_band(16'h0514, 16'h04b0, 0);
        t_band(16'h06a4, 16'h0708, 2);
        t_over();
        t_stop();
        t_alt();
        report_and_stop();
    end

    initial begin
        repeat (12000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end
endmodule
